// [core/bis_pkg.sv]
// Package for the brake interlock sequencer: register map, limits, timing constants
`default_nettype none
package bis_pkg;
    // ==================================================================
    // Timing
    localparam int          CLK_HZ          = 100_000_000;
    localparam int          MS_PER_TICK     = 1;
    localparam int          TICK_CYCLES     = CLK_HZ / 1000 * MS_PER_TICK;
    localparam int          STEP10_MS       = 10;
    // ==================================================================
    // Register byte offsets
    localparam logic [7:0]  OFS_CTRL        = 8'h00;
    localparam logic [7:0]  OFS_SON_WAIT    = 8'h04;
    localparam logic [7:0]  OFS_BASE_DELAY  = 8'h08;
    localparam logic [7:0]  OFS_WAIT_SPEED  = 8'h0c;
    localparam logic [7:0]  OFS_WAIT_TIME   = 8'h10;
    localparam logic [7:0]  OFS_STATUS      = 8'h14;
    localparam logic [7:0]  OFS_IRQ_STAT    = 8'h18;
    localparam logic [7:0]  OFS_IRQ_MASK    = 8'h1c;
    // ==================================================================
    // Reset values and limits
    localparam logic signed [15:0] SON_WAIT_RST = 16'sh0000;
    localparam logic signed [15:0] SON_WAIT_MIN = -16'sd2000;
    localparam logic signed [15:0] SON_WAIT_MAX = 16'sd2000;
    localparam logic [15:0] BASE_DELAY_RST  = 16'h0000;
    localparam logic [15:0] BASE_DELAY_MAX  = 16'h01f4;
    localparam logic [15:0] WAIT_SPEED_RST  = 16'h0064;
    localparam logic [15:0] WAIT_SPEED_MIN  = 16'h000a;
    localparam logic [15:0] WAIT_SPEED_MAX  = 16'h0064;
    localparam logic [15:0] WAIT_TIME_RST   = 16'h0032;
    localparam logic [15:0] WAIT_TIME_MIN   = 16'h000a;
    localparam logic [15:0] WAIT_TIME_MAX   = 16'h0064;
    // ==================================================================
    // Control bit positions and reset value
    localparam int          CTRL_POLICY_BIT = 0;
    localparam int          CTRL_FITTED_BIT = 1;
    localparam int          CTRL_RST        = 0;
    // Event bit positions and vector width
    localparam int          EV_APPLY        = 0;
    localparam int          EV_RELEASE      = 1;
    localparam int          EV_PLOSS        = 2;
    localparam int          EV_TIMEOUT      = 3;
    localparam int          EV_W            = 4;
    // ==================================================================
    // Sequencer states
    typedef enum logic [3:0] {
        ST_OFF  = 4'h1,
        ST_ON   = 4'h2,
        ST_STOP = 4'h4,
        ST_RUN  = 4'h8
    } bis_state_type;
    // Drive inputs grouped
    typedef struct packed {
        logic              servo_on;
        logic              alarm;
        logic              power_loss;
        logic signed [15:0] speed_rpm;
    } bis_drive_type;
endpackage : bis_pkg
`default_nettype wire

// [core/bis_sequencer.sv]
// Brake interlock sequencer top with APB registers and interrupt
//
// Function
// [R1] Defaults: brake applies at servo-on withdrawal
// [R2] Signed servo-on wait, -2000..2000 ms
// [R3] Base wait delay 0..500 tens of ms
// [R4] Running stop: apply below wait speed
// [R5] Running stop: apply after wait time
// [R6] Apply on whichever condition first
// [R7] Servo-off, alarm or power loss start sequence
// [R8] Policy 0: ride through supply dips
// [R9] Policy 1: supply dip raises alarm
// [R10] Output low releases, high applies brake
// [R11] Speed magnitude compared; servo-on clears timeout
`default_nettype none
module bis_sequencer #(
    parameter int TICK_CYCLES = bis_pkg::TICK_CYCLES
) (
    input  wire logic        I_CLK,          // 100 MHz clock
    input  wire logic        I_RESET,        // Sync reset, high
    input  wire logic        I_SERVO_ON,     // Servo-on command pin
    input  wire logic        I_ALARM,        // Drive alarm level
    input  wire logic        I_POWER_LOSS,   // Main supply dip level
    input  wire logic [15:0] I_SPEED,        // Signed motor speed, rpm
    input  wire logic        I_PSEL,         // APB select
    input  wire logic        I_PENABLE,      // APB enable
    input  wire logic        I_PWRITE,       // APB direction
    input  wire logic [7:0]  I_PADDR,        // APB byte address
    input  wire logic [31:0] I_PWDATA,       // APB write data
    output logic [31:0]      O_PRDATA,       // APB read data
    output logic             O_PREADY,       // APB ready
    output logic             O_PSLVERR,      // APB error
    output logic             O_BRAKE_INTERLOCK_OUT, // High applies brake
    output logic             O_MOTOR_POWER,  // Motor power enable
    output logic             O_ALARM_OUT,    // Alarm incl. supply dip
    output logic             O_IRQ           // Level interrupt
);
    // ==================================================================
    // Input synchronisers
    logic [2:0]  pin_s1_q, pin_s2_q;
    logic [15:0] spd_s1_q, spd_s2_q;
    bis_pkg::bis_drive_type drv;

    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            pin_s1_q <= 3'h0;
            pin_s2_q <= 3'h0;
            spd_s1_q <= 16'h0000;
            spd_s2_q <= 16'h0000;
        end
        else
        begin
            pin_s1_q <= {I_SERVO_ON, I_ALARM, I_POWER_LOSS};
            pin_s2_q <= pin_s1_q;
            spd_s1_q <= I_SPEED;
            spd_s2_q <= spd_s1_q;
        end
    end

    always_comb
    begin
        drv.servo_on   = pin_s2_q[2];
        drv.alarm      = pin_s2_q[1];
        drv.power_loss = pin_s2_q[0];
        drv.speed_rpm  = spd_s2_q;
    end

    // ==================================================================
    // Registers
    logic [1:0]          ctrl_q, ctrl_d;
    logic signed [15:0]  son_wait_q, son_wait_d;
    logic [15:0]         base_q, base_d, wspd_q, wspd_d, wtim_q, wtim_d;
    logic [bis_pkg::EV_W-1:0] ist_q, ist_d, imask_q, imask_d;
    logic [bis_pkg::EV_W-1:0] ev;
    logic                wr, rd;
    logic signed [15:0]  wval;
    logic [15:0]         uval;

    assign wr = I_PSEL && I_PENABLE && I_PWRITE;
    assign rd = I_PSEL && !I_PWRITE;

    // Writes clamp into range so the sequencer never sees an illegal setting
    always_comb
    begin
        wval       = I_PWDATA[15:0];
        uval       = I_PWDATA[15:0];
        ctrl_d     = ctrl_q;
        son_wait_d = son_wait_q;
        base_d     = base_q;
        wspd_d     = wspd_q;
        wtim_d     = wtim_q;
        imask_d    = imask_q;
        ist_d      = ist_q;
        if (wr)
        begin
            case (I_PADDR)
                bis_pkg::OFS_CTRL:       ctrl_d = I_PWDATA[1:0];
                bis_pkg::OFS_SON_WAIT:                                    // R2
                    son_wait_d = (wval < bis_pkg::SON_WAIT_MIN) ? bis_pkg::SON_WAIT_MIN :
                                 (wval > bis_pkg::SON_WAIT_MAX) ? bis_pkg::SON_WAIT_MAX : wval;
                bis_pkg::OFS_BASE_DELAY:                                  // R3
                    base_d = (uval > bis_pkg::BASE_DELAY_MAX) ? bis_pkg::BASE_DELAY_MAX : uval;
                bis_pkg::OFS_WAIT_SPEED:                                  // R4
                    wspd_d = (uval < bis_pkg::WAIT_SPEED_MIN) ? bis_pkg::WAIT_SPEED_MIN :
                             (uval > bis_pkg::WAIT_SPEED_MAX) ? bis_pkg::WAIT_SPEED_MAX : uval;
                bis_pkg::OFS_WAIT_TIME:                                   // R5
                    wtim_d = (uval < bis_pkg::WAIT_TIME_MIN) ? bis_pkg::WAIT_TIME_MIN :
                             (uval > bis_pkg::WAIT_TIME_MAX) ? bis_pkg::WAIT_TIME_MAX : uval;
                bis_pkg::OFS_IRQ_STAT:   ist_d = ist_q & ~I_PWDATA[bis_pkg::EV_W-1:0];
                bis_pkg::OFS_IRQ_MASK:   imask_d = I_PWDATA[bis_pkg::EV_W-1:0];
                default:                 ctrl_d = ctrl_q;
            endcase
        end
        // Set wins over a clear in the same cycle
        ist_d = ist_d | ev;
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            ctrl_q     <= 2'(bis_pkg::CTRL_RST);
            son_wait_q <= bis_pkg::SON_WAIT_RST;
            base_q     <= bis_pkg::BASE_DELAY_RST;
            wspd_q     <= bis_pkg::WAIT_SPEED_RST;
            wtim_q     <= bis_pkg::WAIT_TIME_RST;
            ist_q      <= 4'h0;
            imask_q    <= 4'h0;
        end
        else
        begin
            ctrl_q     <= ctrl_d;
            son_wait_q <= son_wait_d;
            base_q     <= base_d;
            wspd_q     <= wspd_d;
            wtim_q     <= wtim_d;
            ist_q      <= ist_d;
            imask_q    <= imask_d;
        end
    end

    // ==================================================================
    // Sequencer
    bis_pkg::bis_state_type st_q, st_d;
    logic         brake_q, brake_d, power_q, power_d, load;
    logic [19:0]  load_val;
    logic         tick, tzero, stop_req, running, slow, dip_alarm;
    logic [15:0]  spd_abs;
    logic [19:0]  base_ms, son_abs;

    assign spd_abs   = drv.speed_rpm[15] ? 16'(-drv.speed_rpm) : drv.speed_rpm; // R11
    assign slow      = spd_abs < wspd_q;                                         // R4
    assign running   = !slow;
    assign dip_alarm = drv.power_loss && ctrl_q[bis_pkg::CTRL_POLICY_BIT];       // R8 R9
    assign stop_req  = !drv.servo_on || drv.alarm || dip_alarm;                 // R7
    assign base_ms   = 20'(base_q * 16'(bis_pkg::STEP10_MS));
    assign son_abs   = 20'(son_wait_q[15] ? 16'(-son_wait_q) : son_wait_q);

    bis_timer #(
        .TICK_CYCLES (TICK_CYCLES)
    ) u_timer (
        .i_clk   (I_CLK),
        .i_reset (I_RESET),
        .i_load  (load),
        .i_value (load_val),
        .o_tick  (tick),
        .o_zero  (tzero)
    );

    // Stopped-motor path: a positive wait holds power after the brake applies,
    // a negative wait removes power first; base delay adds to both sides.
    always_comb
    begin
        st_d     = st_q;
        brake_d  = brake_q;
        power_d  = power_q;
        load     = 1'b0;
        load_val = 20'h00000;
        ev       = '0;
        ev[bis_pkg::EV_PLOSS] = drv.power_loss && !dip_alarm;
        case (st_q)
            bis_pkg::ST_OFF:
            begin
                brake_d = 1'b1;
                power_d = 1'b0;
                if (!stop_req)
                begin
                    st_d    = bis_pkg::ST_ON;
                    power_d = 1'b1;
                    brake_d = 1'b0;                                      // R10
                    load    = 1'b1;                                      // R11
                    ev[bis_pkg::EV_RELEASE] = 1'b1;
                end
            end
            bis_pkg::ST_ON:
            begin
                if (stop_req && running)
                begin
                    st_d     = bis_pkg::ST_RUN;                          // R7
                    power_d  = 1'b0;
                    load     = 1'b1;
                    load_val = 20'(wtim_q * 16'(bis_pkg::STEP10_MS));     // R5
                end
                else if (stop_req)
                begin
                    st_d = bis_pkg::ST_STOP;
                    load = 1'b1;
                    if (son_wait_q[15])
                    begin
                        power_d  = 1'b0;                                 // R2
                        load_val = 20'(son_abs + base_ms);
                    end
                    else
                    begin
                        brake_d  = 1'b1;                                 // R1
                        ev[bis_pkg::EV_APPLY] = 1'b1;
                        load_val = 20'(son_abs + base_ms);               // R3
                        if (load_val == 20'h00000)
                            power_d = 1'b0;
                    end
                end
            end
            bis_pkg::ST_STOP:
            begin
                if (tzero)
                begin
                    if (!brake_q)
                        ev[bis_pkg::EV_APPLY] = 1'b1;
                    brake_d = 1'b1;
                    power_d = 1'b0;
                    st_d    = bis_pkg::ST_OFF;
                end
            end
            bis_pkg::ST_RUN:
            begin
                if (slow || tzero)                                       // R6
                begin
                    brake_d = 1'b1;
                    st_d    = bis_pkg::ST_OFF;
                    ev[bis_pkg::EV_APPLY]   = 1'b1;
                    ev[bis_pkg::EV_TIMEOUT] = !slow;
                end
            end
            default:
            begin
                st_d    = bis_pkg::ST_OFF;
                brake_d = 1'b1;
                power_d = 1'b0;
            end
        endcase
    end

    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
        begin
            st_q    <= bis_pkg::ST_OFF;
            brake_q <= 1'b1;
            power_q <= 1'b0;
        end
        else
        begin
            st_q    <= st_d;
            brake_q <= brake_d;
            power_q <= power_d;
        end
    end

    // ==================================================================
    // Outputs and APB read
    assign O_BRAKE_INTERLOCK_OUT = brake_q || !ctrl_q[bis_pkg::CTRL_FITTED_BIT] ? 1'b1 : 1'b0; // R10
    assign O_MOTOR_POWER = power_q;
    assign O_ALARM_OUT   = drv.alarm || dip_alarm;                       // R9
    assign O_IRQ         = |(ist_q & imask_q);
    assign O_PREADY      = 1'b1;                                         // Zero wait states
    assign O_PSLVERR     = 1'b0;

    always_comb
    begin
        O_PRDATA = 32'h00000000;
        if (rd)
        begin
            case (I_PADDR)
                bis_pkg::OFS_CTRL:       O_PRDATA = {30'h0, ctrl_q};
                bis_pkg::OFS_SON_WAIT:   O_PRDATA = {{16{son_wait_q[15]}}, son_wait_q};
                bis_pkg::OFS_BASE_DELAY: O_PRDATA = {16'h0000, base_q};
                bis_pkg::OFS_WAIT_SPEED: O_PRDATA = {16'h0000, wspd_q};
                bis_pkg::OFS_WAIT_TIME:  O_PRDATA = {16'h0000, wtim_q};
                bis_pkg::OFS_STATUS:     O_PRDATA = {26'h0, power_q, brake_q, st_q};
                bis_pkg::OFS_IRQ_STAT:   O_PRDATA = {28'h0, ist_q};
                bis_pkg::OFS_IRQ_MASK:   O_PRDATA = {28'h0, imask_q};
                default:                 O_PRDATA = 32'h00000000;
            endcase
        end
    end
endmodule // bis_sequencer
`default_nettype wire

// [core/bis_timer.sv]
// Millisecond tick divider and loadable down counter for the sequencer
`default_nettype none
module bis_timer #(
    parameter int TICK_CYCLES = 100000
) (
    input  wire logic        i_clk,    // System clock
    input  wire logic        i_reset,  // Sync reset, high
    input  wire logic        i_load,   // Load count
    input  wire logic [19:0] i_value,  // Count in ms
    output logic             o_tick,   // One-cycle ms pulse
    output logic             o_zero    // Count reached zero
);
    logic [16:0] div_q, div_d;
    logic [19:0] cnt_q, cnt_d;

    // ==================================================================
    // Divider and counter next state
    always_comb
    begin
        o_tick = (div_q == 17'(TICK_CYCLES - 1));
        div_d  = o_tick ? 17'h00000 : div_q + 17'h00001;
        cnt_d  = cnt_q;
        if (i_load)
            cnt_d = i_value;
        else if (o_tick && cnt_q != 20'h00000)
            cnt_d = cnt_q - 20'h00001;
        o_zero = (cnt_q == 20'h00000);
    end

    // Registers
    always_ff @(posedge i_clk)
    begin
        if (i_reset)
        begin
            div_q <= 17'h00000;
            cnt_q <= 20'h00000;
        end
        else
        begin
            div_q <= div_d;
            cnt_q <= cnt_d;
        end
    end
endmodule // bis_timer
`default_nettype wire

// [tb/bis_brake_relay.sv]
// Holding-brake relay model driven by the interlock output
`default_nettype none
module bis_brake_relay #(
    parameter int PULL_IN = 2
) (
    input  wire logic i_clk,   // Clock
    input  wire logic i_coil,  // High applies brake
    output var logic  o_held   // Brake engaged
);
    timeunit 1ns;
    timeprecision 1ps;
    int cnt = 0;
    initial o_held = 1'b1;
    // ===============================================================
    // Contact settles slowly, so a one-cycle glitch never moves it
    always @(posedge i_clk)
    begin
        cnt = (i_coil == o_held) ? 0 : cnt + 1;
        if (cnt >= PULL_IN)
            o_held <= i_coil;
    end
endmodule // bis_brake_relay
`default_nettype wire

// [tb/bis_checker.sv]
// Port checker for the brake interlock sequencer
`default_nettype none
module bis_checker #(
    parameter int TICK_CYCLES = 10
) (
    input wire logic        I_CLK,                 // Clock
    input wire logic        I_RESET,               // Reset
    input wire logic        I_SERVO_ON,            // Servo-on
    input wire logic        I_ALARM,               // Alarm
    input wire logic        I_POWER_LOSS,          // Supply dip
    input wire logic [15:0] I_SPEED,               // Speed
    input wire logic        I_PSEL,                // APB select
    input wire logic        I_PENABLE,             // APB enable
    input wire logic        I_PWRITE,              // APB write
    input wire logic [7:0]  I_PADDR,               // APB address
    input wire logic [31:0] I_PWDATA,              // APB wdata
    input wire logic [31:0] O_PRDATA,              // APB rdata
    input wire logic        O_PREADY,              // APB ready
    input wire logic        O_PSLVERR,             // APB error
    input wire logic        O_BRAKE_INTERLOCK_OUT, // Brake
    input wire logic        O_MOTOR_POWER,         // Power
    input wire logic        O_ALARM_OUT,           // Alarm out
    input wire logic        O_IRQ                  // Interrupt
);
    timeunit 1ns;
    timeprecision 1ps;
    // Worst stop: 1000 ms timeout plus 7000 ms of waits, with margin
    localparam int LIMIT = 8200 * TICK_CYCLES;
    logic fit_q, pol_q, a1_q, a2_q, p1_q, p2_q, s1_q, s2_q;
    int   since_q, stop_q;
    logic ok, stop;
    assign ok   = since_q >= 3;
    assign stop = ok && (!s2_q || a2_q || (p2_q && pol_q));
    // ===============================================================
    // Shadow of CTRL and of the input synchronisers
    always_ff @(posedge I_CLK)
    begin
        if (I_RESET)
            {fit_q, pol_q, a1_q, a2_q, p1_q, p2_q, s1_q, s2_q} <= 8'h00;
        else
        begin
            if (I_PSEL && I_PENABLE && I_PWRITE && I_PADDR == bis_pkg::OFS_CTRL)
                {fit_q, pol_q} <= I_PWDATA[1:0];
            {a2_q, a1_q, p2_q, p1_q} <= {a1_q, I_ALARM, p1_q, I_POWER_LOSS};
            {s2_q, s1_q} <= {s1_q, I_SERVO_ON};
        end
        since_q <= I_RESET ? 0 : (ok ? since_q : since_q + 1);
        stop_q  <= (I_RESET || !stop || O_BRAKE_INTERLOCK_OUT) ? 0 : stop_q + 1;
    end
    default clocking cb @(posedge I_CLK); endclocking
    default disable iff (I_RESET);
    // ===============================================================
    // Assertions
    apb_answer_a: assert property (O_PREADY && !O_PSLVERR)
        else $error("apb answer wrong");
    reset_safe_a: assert property ($fell(I_RESET) |-> O_BRAKE_INTERLOCK_OUT && !O_MOTOR_POWER)
        else $error("not safe after reset");
    unmapped_rd_a: assert property (I_PSEL && !I_PWRITE && I_PADDR >= 8'h20 |-> O_PRDATA == 32'h0)
        else $error("unmapped read not zero");
    unfitted_hold_a: assert property (!fit_q && !$past(fit_q) |-> O_BRAKE_INTERLOCK_OUT)
        else $error("brake released without fitted");
    release_cause_a: assert property ($fell(O_BRAKE_INTERLOCK_OUT) |->
        $past(I_SERVO_ON, 2) || $past(I_SERVO_ON, 3) || $past(I_SERVO_ON, 4))
        else $error("release without servo on");
    stop_bound_a: assert property (stop_q < LIMIT)
        else $error("brake not applied in time");
    alarm_path_a: assert property (ok && (a2_q || (p2_q && pol_q)) |-> O_ALARM_OUT)
        else $error("alarm output missing");
    ride_through_a: assert property (ok && !a2_q && !(p2_q && pol_q) |-> !O_ALARM_OUT)
        else $error("spurious alarm output");
    cover property ($rose(O_BRAKE_INTERLOCK_OUT));
    cover property ($rose(O_IRQ));
    cover property (p2_q && !pol_q && !O_BRAKE_INTERLOCK_OUT);
endmodule // bis_checker
bind bis_sequencer bis_checker #(.TICK_CYCLES(TICK_CYCLES)) u_chk (
    .I_CLK(I_CLK), .I_RESET(I_RESET), .I_SERVO_ON(I_SERVO_ON), .I_ALARM(I_ALARM),
    .I_POWER_LOSS(I_POWER_LOSS), .I_SPEED(I_SPEED), .I_PSEL(I_PSEL), .I_PENABLE(I_PENABLE),
    .I_PWRITE(I_PWRITE), .I_PADDR(I_PADDR), .I_PWDATA(I_PWDATA), .O_PRDATA(O_PRDATA),
    .O_PREADY(O_PREADY), .O_PSLVERR(O_PSLVERR), .O_MOTOR_POWER(O_MOTOR_POWER),
    .O_BRAKE_INTERLOCK_OUT(O_BRAKE_INTERLOCK_OUT), .O_ALARM_OUT(O_ALARM_OUT), .O_IRQ(O_IRQ));
`default_nettype wire

// [tb/bis_sequencer_tb.sv]
// Self-checking bench for the brake interlock sequencer
`default_nettype none
module bis_sequencer_tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 10;
    logic clk = 1'b0, rst = 1'b1, son = 1'b0, alm = 1'b0, dip = 1'b0;
    logic psel = 1'b0, pen = 1'b0, pwr = 1'b0;
    logic [15:0] spd = 16'h0000;
    logic [7:0]  pa = 8'h00;
    logic [31:0] pwd = 32'h0, prd, rd, seed = 32'h55;
    logic rdy, err, brk, mpow, aout, irq, held;
    int n_fail = 0, checks = 0, n, run, exp_cyc;
    logic [7:0]  ofs [4] = '{bis_pkg::OFS_SON_WAIT, bis_pkg::OFS_BASE_DELAY,
                             bis_pkg::OFS_WAIT_SPEED, bis_pkg::OFS_WAIT_TIME};
    logic [15:0] dft [4] = '{bis_pkg::SON_WAIT_RST, bis_pkg::BASE_DELAY_RST,
                             bis_pkg::WAIT_SPEED_RST, bis_pkg::WAIT_TIME_RST};
    logic [15:0] lim [4] = '{bis_pkg::SON_WAIT_MAX, bis_pkg::BASE_DELAY_MAX,
                             bis_pkg::WAIT_SPEED_MIN, bis_pkg::WAIT_TIME_MIN};
    logic [15:0] bad [4] = '{16'h7fff, 16'hffff, 16'h0001, 16'h0001};
    always #5 clk = ~clk;
    bis_sequencer #(.TICK_CYCLES(TK)) u_dut (
        .I_CLK(clk), .I_RESET(rst), .I_SERVO_ON(son), .I_ALARM(alm), .I_POWER_LOSS(dip),
        .I_SPEED(spd), .I_PSEL(psel), .I_PENABLE(pen), .I_PWRITE(pwr), .I_PADDR(pa),
        .I_PWDATA(pwd), .O_PRDATA(prd), .O_PREADY(rdy), .O_PSLVERR(err),
        .O_BRAKE_INTERLOCK_OUT(brk), .O_MOTOR_POWER(mpow), .O_ALARM_OUT(aout), .O_IRQ(irq));
    bis_brake_relay u_relay (.i_clk(clk), .i_coil(brk), .o_held(held));
    // ===============================================================
    // Helpers
    function automatic logic [31:0] xs(input logic [31:0] x);
        x = x ^ (x << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Cycles from stop to the delayed action: |wait| ms plus base steps
    function automatic int stop_cyc(input int w, input int b);
        return ((w < 0 ? -w : w) + b * bis_pkg::STEP10_MS) * TK;
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp)
        begin
            n_fail++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    // Request held until pready is seen high, data taken at that edge
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge clk);
        {psel, pen, pwr, pa, pwd} <= {2'b10, w, a, d};
        @(posedge clk);
        pen <= 1'b1;
        do @(posedge clk); while (rdy !== 1'b1);
        rd = prd;
        {psel, pen} <= 2'b00;
    endtask
    task automatic wait_brk(input logic v, input int mx);
        n = 0;
        while (brk !== v && n < mx)
        begin
            @(posedge clk);
            n++;
        end
    endtask
    task automatic go(input logic s, input logic [15:0] v);
        @(posedge clk);
        {son, spd} <= {s, v};
    endtask
    task automatic wrap_up;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    // ===============================================================
    // Watchdog: the sequence needs well under 20000 cycles
    initial
    begin
        #400000;
        n_fail++;
        wrap_up();
    end
    // ===============================================================
    // Main sequence
    initial
    begin
        repeat (10) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk({brk, mpow, irq}, 3'b100);
        for (int i = 0; i < 4; i++)
        begin
            apb(1'b0, ofs[i], 32'h0);
            chk(rd[15:0], dft[i]);
            apb(1'b1, ofs[i], {16'h0, bad[i]});
            apb(1'b0, ofs[i], 32'h0);
            chk(rd[15:0], lim[i]);
            apb(1'b1, ofs[i], {16'h0, dft[i]});
        end
        apb(1'b1, 8'h20, 32'hffff_ffff);
        apb(1'b0, 8'h20, 32'h0);
        chk(rd, 32'h0);
        // Defaults: brake follows servo-on with no wait
        apb(1'b1, bis_pkg::OFS_CTRL, 32'h2);
        go(1'b1, 16'h0000);
        wait_brk(1'b0, 100);
        chk({brk, mpow}, 2'b01);
        go(1'b0, 16'h0000);
        wait_brk(1'b1, 20);
        chk(n <= 4, 1'b1);
        repeat (4) @(posedge clk);
        chk(held, 1'b1);
        // Running reverse: only the wait time ends it
        apb(1'b1, bis_pkg::OFS_WAIT_TIME, 32'ha);
        seed = xs(seed);
        run = 200 + seed % 800;
        go(1'b1, 16'(-run));
        wait_brk(1'b0, 100);
        go(1'b0, 16'(-run));
        wait_brk(1'b1, 3000);
        run = 10 * bis_pkg::STEP10_MS * TK;
        chk(n >= run - 20 && n <= run + 40, 1'b1);
        @(posedge clk);
        chk(irq, 1'b0);
        apb(1'b1, bis_pkg::OFS_IRQ_MASK, 32'h1 << bis_pkg::EV_TIMEOUT);
        @(posedge clk);
        chk(irq, 1'b1);
        apb(1'b0, bis_pkg::OFS_IRQ_STAT, 32'h0);
        chk(rd[bis_pkg::EV_TIMEOUT], 1'b1);
        apb(1'b1, bis_pkg::OFS_IRQ_STAT, 32'h1 << bis_pkg::EV_TIMEOUT);
        @(posedge clk);
        chk(irq, 1'b0);
        // Alarm, then supply dip under policy 1: stop on falling speed
        for (int c = 0; c < 2; c++)
        begin
            apb(1'b1, bis_pkg::OFS_CTRL, 32'(2 + c));
            seed = xs(seed);
            run = 200 + seed % 800;
            go(1'b1, seed[8] ? 16'(run) : 16'(-run));
            wait_brk(1'b0, 100);
            {alm, dip} <= c ? 2'b01 : 2'b10;
            repeat (200) @(posedge clk);
            chk(brk, 1'b0);
            chk(aout, 1'b1);
            go(1'b1, 16'(seed[20:14] % 100));
            wait_brk(1'b1, 40);
            chk(n < 10, 1'b1);
            go(1'b0, 16'h0000);
            {alm, dip} <= 2'b00;
            repeat (20) @(posedge clk);
        end
        // Policy 0: a dip is ridden through
        apb(1'b1, bis_pkg::OFS_CTRL, 32'h2);
        go(1'b1, 16'h0000);
        wait_brk(1'b0, 100);
        dip <= 1'b1;
        repeat (50) @(posedge clk);
        chk({brk, aout, mpow}, 3'b001);
        dip <= 1'b0;
        repeat (5) @(posedge clk);
        // Unfitted brake forces the output to apply, even with servo on
        apb(1'b1, bis_pkg::OFS_CTRL, 32'h0);
        @(posedge clk);
        chk(brk, 1'b1);
        apb(1'b1, bis_pkg::OFS_CTRL, 32'h2);
        wait_brk(1'b0, 10);
        chk(brk, 1'b0);
        // Stopped motor: random signed servo-on wait plus base delay
        seed = xs(seed);
        run = int'(seed % 200) - 100;
        apb(1'b1, bis_pkg::OFS_SON_WAIT, 32'(run));
        apb(1'b1, bis_pkg::OFS_BASE_DELAY, 32'h2);
        exp_cyc = stop_cyc(run, 2);
        go(1'b0, 16'h0000);
        wait_brk(1'b1, 3000);
        if (run < 0)
        begin
            chk(n >= exp_cyc - 20 && n <= exp_cyc + 20, 1'b1);
            chk(mpow, 1'b0);
        end
        else
        begin
            chk(n <= 4, 1'b1);
            repeat (exp_cyc - 20) @(posedge clk);
            chk(mpow, 1'b1);
            repeat (40) @(posedge clk);
            chk(mpow, 1'b0);
        end
        wrap_up();
    end
endmodule // bis_sequencer_tb
`default_nettype wire
